// *** logic/rsrm_pkg.sv ***
// constants and types of the reset source and remap block
// Function
// R1 - remap bit set: bottom of address space, from zero, decodes to sram
// R2 - every reset clears the remap bit, bringing flash back to zero
// R3 - software writes zeros to remap control bits 7 to 1
// R4 - software changes remap only from code at the absolute flash address
// R5 - the reset handler lives in flash, present at the vector after reset
// R6 - four sources recorded: pin, power-on, watchdog, software
// R7 - external pin reset sets status bit 3
// R8 - writing one to status bit 2 causes software reset; bit stays set
// R9 - watchdog timeout reset sets status bit 1
// R10 - power-on reset sets status bit 0
// R11 - status bits 7 to 4 always read as zero
// R12 - write-only clear register: each one written clears that status bit
// R13 - clear write leaving software flag set triggers another software reset
// R14 - a reset after serial-link download marks sram contents invalid
// R15 - with low voltage flagging on, sram survives power-on only if flag set
// R16 - source flags are sticky across resets until cleared by software
`default_nettype none
package rsrm_pkg;

  localparam logic [31:0] ADDR_REMAP  = 32'hFFFF0220;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFF0230;
  localparam logic [31:0] ADDR_CLEAR  = 32'hFFFF0234;

  localparam int REMAP_BIT = 0;
  localparam int ST_POR    = 0;
  localparam int ST_WDT    = 1;
  localparam int ST_SW     = 2;
  localparam int ST_EXT    = 3;
  localparam int CFG_LVF_EN = 2;
  localparam int STA_LVF    = 6;

  localparam logic [7:0] STATUS_USED  = 8'h0F;
  localparam logic       REMAP_RESET  = 1'b0;
  localparam logic [7:0] STATUS_RESET = 8'h01;

  localparam logic [31:0] LOW_REGION_BYTES = 32'h00007800;

  localparam int CLK_PERIOD_NS  = 5;
  localparam int RESET_HOLD_NS  = 80;
  localparam logic [7:0] RESET_HOLD_CYCLES =
    8'((RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } rsrm_req_type;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } rsrm_rsp_type;

  typedef enum logic [1:0] {
    RSRM_RUN  = 2'b01,
    RSRM_HOLD = 2'b10
  } rsrm_state_type;

endpackage
`default_nettype wire

// *** logic/rsrm_top.sv ***
// reset source capture, software reset and memory remap control
`default_nettype none
module rsrm_top (
  // clock and power-on reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // memory-mapped register port
  input  wire rsrm_pkg::rsrm_req_type req,
  output var  rsrm_pkg::rsrm_rsp_type rsp,
  // reset event inputs and download status
  input  wire logic              ext_pin_reset,
  input  wire logic              watchdog_timeout,
  input  wire logic              download_done,
  // high voltage interface levels
  input  wire logic [7:0]        high_voltage_config,
  input  wire logic [7:0]        high_voltage_status,
  // core address decode
  input  wire logic [31:0]       core_addr,
  output logic                   sel_low_sram,
  output logic                   sel_low_flash,
  // system outputs
  output logic                   system_reset_n,
  output logic                   remap_sram,
  output logic                   sram_valid
);

  // reset release through two flops
  logic                     rst_meta_n;
  logic                     rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // sequencing state and source flags, read by the decode below
  rsrm_pkg::rsrm_state_type state;
  rsrm_pkg::rsrm_state_type next_state;
  logic [7:0]               hold_count;
  logic [7:0]               status;

  // register decode
  logic                     bus_open;
  logic                     wr_remap;
  logic                     wr_status;
  logic                     wr_clear;
  logic                     rd_hit_remap;
  logic                     rd_hit_status;
  logic                     hit_clear;

  rsrm_addr_hit #(
    .ADDR (rsrm_pkg::ADDR_REMAP)
  ) hit_remap_i (
    .addr (req.addr),
    .hit  (rd_hit_remap)
  );

  rsrm_addr_hit #(
    .ADDR (rsrm_pkg::ADDR_STATUS)
  ) hit_status_i (
    .addr (req.addr),
    .hit  (rd_hit_status)
  );

  rsrm_addr_hit #(
    .ADDR (rsrm_pkg::ADDR_CLEAR)
  ) hit_clear_i (
    .addr (req.addr),
    .hit  (hit_clear)
  );

  // the core sits in reset during the hold, so its port is closed then
  assign bus_open      = (state == rsrm_pkg::RSRM_RUN);
  assign wr_remap      = bus_open && req.wr && rd_hit_remap;
  assign wr_status     = bus_open && req.wr && rd_hit_status;
  assign wr_clear      = bus_open && req.wr && hit_clear;

  // software reset requests
  logic                     sw_by_status;
  logic                     sw_by_clear;
  logic                     sw_reset;

  assign sw_by_status = wr_status && req.wdata[rsrm_pkg::ST_SW]; // [R8]
  // a clear that leaves the software flag standing resets again
  assign sw_by_clear  = wr_clear && status[rsrm_pkg::ST_SW]
                        && !req.wdata[rsrm_pkg::ST_SW]; // [R13]
  assign sw_reset     = sw_by_status || sw_by_clear;

  // reset events that restart the system
  logic                     any_event;

  assign any_event = ext_pin_reset || watchdog_timeout || sw_reset; // [R6]

  // reset sequencing
  always_comb begin
    next_state = state;
    case (state)
      rsrm_pkg::RSRM_RUN: begin
        if (any_event) begin
          next_state = rsrm_pkg::RSRM_HOLD;
        end
      end
      rsrm_pkg::RSRM_HOLD: begin
        if (!any_event && hold_count == 8'h01) begin
          next_state = rsrm_pkg::RSRM_RUN;
        end
      end
      default: begin
        next_state = rsrm_pkg::RSRM_HOLD;
      end
    endcase
  end

  // power-on enters the hold so the system sees a full reset pulse
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= rsrm_pkg::RSRM_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // a new event during the hold restarts the count
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hold_count <= rsrm_pkg::RESET_HOLD_CYCLES;
    end else if (any_event) begin
      hold_count <= rsrm_pkg::RESET_HOLD_CYCLES;
    end else if (state == rsrm_pkg::RSRM_HOLD && hold_count != 8'h00) begin
      hold_count <= hold_count - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      system_reset_n <= 1'b0;
    end else begin
      system_reset_n <= (next_state == rsrm_pkg::RSRM_RUN);
    end
  end

  // reset source flags
  logic [7:0]               set_bits;
  logic [7:0]               clr_bits;

  always_comb begin
    set_bits = 8'h00;
    set_bits[rsrm_pkg::ST_EXT] = ext_pin_reset; // [R7]
    set_bits[rsrm_pkg::ST_WDT] = watchdog_timeout; // [R9]
    set_bits[rsrm_pkg::ST_SW]  = sw_by_status; // [R8]
  end

  assign clr_bits = wr_clear ? req.wdata : 8'h00; // [R12]

  // status survives every reset but power-on; a set beats a clear
  rsrm_flag #(
    .RESET_VALUE (rsrm_pkg::STATUS_RESET[rsrm_pkg::ST_POR])
  ) flag_por_i (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .set   (set_bits[rsrm_pkg::ST_POR]),
    .clear (clr_bits[rsrm_pkg::ST_POR]),
    .flag  (status[rsrm_pkg::ST_POR])
  ); // [R10] [R16]

  rsrm_flag #(
    .RESET_VALUE (rsrm_pkg::STATUS_RESET[rsrm_pkg::ST_WDT])
  ) flag_wdt_i (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .set   (set_bits[rsrm_pkg::ST_WDT]),
    .clear (clr_bits[rsrm_pkg::ST_WDT]),
    .flag  (status[rsrm_pkg::ST_WDT])
  ); // [R16]

  rsrm_flag #(
    .RESET_VALUE (rsrm_pkg::STATUS_RESET[rsrm_pkg::ST_SW])
  ) flag_sw_i (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .set   (set_bits[rsrm_pkg::ST_SW]),
    .clear (clr_bits[rsrm_pkg::ST_SW]),
    .flag  (status[rsrm_pkg::ST_SW])
  ); // [R16]

  rsrm_flag #(
    .RESET_VALUE (rsrm_pkg::STATUS_RESET[rsrm_pkg::ST_EXT])
  ) flag_ext_i (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .set   (set_bits[rsrm_pkg::ST_EXT]),
    .clear (clr_bits[rsrm_pkg::ST_EXT]),
    .flag  (status[rsrm_pkg::ST_EXT])
  ); // [R16]

  assign status[7:4] = 4'h0; // [R11]

  // remap control
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      remap_sram <= rsrm_pkg::REMAP_RESET;
    end else if (any_event || state == rsrm_pkg::RSRM_HOLD) begin
      remap_sram <= rsrm_pkg::REMAP_RESET; // [R2]
    end else if (wr_remap) begin
      remap_sram <= req.wdata[rsrm_pkg::REMAP_BIT];
    end
  end

  // low region decode; software must run from absolute flash to switch
  logic                     low_region;

  assign low_region    = core_addr < rsrm_pkg::LOW_REGION_BYTES;
  assign sel_low_sram  = low_region && remap_sram; // [R1] [R4]
  assign sel_low_flash = low_region && !remap_sram; // [R5]

  // sram validity
  logic                     por_pending;
  logic                     lvf_enabled;
  logic                     lvf_kept;

  assign lvf_enabled = high_voltage_config[rsrm_pkg::CFG_LVF_EN];
  assign lvf_kept    = high_voltage_status[rsrm_pkg::STA_LVF];

  // levels are caught on the first edge after release, not by the reset
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      por_pending <= 1'b1;
    end else begin
      por_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sram_valid <= 1'b0;
    end else if (por_pending) begin
      sram_valid <= lvf_enabled && lvf_kept; // [R15]
    end else if (any_event) begin
      sram_valid <= !download_done; // [R14]
    end
  end

  // read path; clear register and unmapped addresses read zero
  logic [7:0]               next_rdata;

  always_comb begin
    next_rdata = 8'h00;
    if (rd_hit_remap) begin
      next_rdata[rsrm_pkg::REMAP_BIT] = remap_sram;
    end else if (rd_hit_status) begin
      next_rdata = status & rsrm_pkg::STATUS_USED; // [R11]
    end
  end

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rsp <= '0;
    end else begin
      rsp.rvalid <= req.rd && bus_open;
      rsp.rdata  <= (req.rd && bus_open) ? next_rdata : 8'h00;
    end
  end

endmodule

// one sticky status flag; a set beats a clear in the same cycle
module rsrm_flag #(
  parameter logic RESET_VALUE = 1'b0
) (
  // clock and synchronised reset
  input  wire logic clk,
  input  wire logic rst_n,
  // flag control
  input  wire logic set,
  input  wire logic clear,
  // stored flag
  output logic      flag
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag <= RESET_VALUE;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end

endmodule

// exact match of the core's byte address against one register
module rsrm_addr_hit #(
  parameter logic [31:0] ADDR = 32'h00000000
) (
  // core address
  input  wire logic [31:0] addr,
  // match
  output logic             hit
);

  assign hit = (addr == ADDR);

endmodule
`default_nettype wire

// *** tb/rsrm_top_props.sv ***
// assertion checker for the reset source and remap block
`default_nettype none
module rsrm_top_chk (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // register port
  input wire rsrm_pkg::rsrm_req_type req,
  input wire rsrm_pkg::rsrm_rsp_type rsp,
  // events and levels
  input wire logic                   ext_pin_reset,
  input wire logic                   watchdog_timeout,
  input wire logic                   download_done,
  input wire logic [31:0]            core_addr,
  // outputs
  input wire logic                   sel_low_sram,
  input wire logic                   sel_low_flash,
  input wire logic                   system_reset_n,
  input wire logic                   remap_sram,
  input wire logic                   sram_valid
);
  logic       ev_now;
  logic [7:0] low_cnt;
  assign ev_now = ext_pin_reset || watchdog_timeout;
  // restarts on each event, so it measures only the quiet tail of a hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) low_cnt <= 8'h00;
    else if (system_reset_n || ev_now) low_cnt <= 8'h00;
    else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence ev;
    watchdog_timeout || ext_pin_reset;
  endsequence
  sequence sw_wr;
    system_reset_n && req.wr && req.wdata[2] &&
    req.addr == rsrm_pkg::ADDR_STATUS;
  endsequence
  chk_sram_decode: assert property (sel_low_sram ==
    (remap_sram && core_addr < rsrm_pkg::LOW_REGION_BYTES))
    else $error("sram select wrong");
  chk_flash_decode: assert property (sel_low_flash ==
    (!remap_sram && core_addr < rsrm_pkg::LOW_REGION_BYTES))
    else $error("flash select wrong");
  chk_event_remap: assert property (ev |=> !remap_sram && !system_reset_n)
    else $error("event did not reset");
  chk_sw_reset: assert property (sw_wr |=> !system_reset_n && !remap_sram)
    else $error("software reset missing");
  chk_hold_len: assert property ($rose(system_reset_n) |->
    low_cnt inside {[8'h10:8'h12]}) else $error("hold length wrong");
  chk_unused_zero: assert property (rsp.rvalid |-> rsp.rdata[7:4] == 4'h0)
    else $error("upper read bits set");
  chk_read_answer: assert property (system_reset_n && req.rd && !ev_now
    |=> rsp.rvalid) else $error("read not answered");
  chk_sram_event: assert property (watchdog_timeout |=>
    sram_valid == !$past(download_done)) else $error("sram valid wrong");
endmodule
bind rsrm_top rsrm_top_chk rsrm_top_chk_i (.*);
`default_nettype wire

// *** tb/rsrm_core_model.sv ***
// core side model: byte register accesses launched on the falling edge
`default_nettype none
module rsrm_core_model (
  // clock
  input  wire logic                   clk,
  // register port
  output var  rsrm_pkg::rsrm_req_type req,
  input  wire rsrm_pkg::rsrm_rsp_type rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  initial req = '0;
  // code runs from absolute flash, so no fetch side is modelled
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    req <= '0;
  endtask
  // a missing answer comes back unknown so any compare fails
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    @(negedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge clk);
    // the answer stands for one cycle only, so take it now
    d = (rsp.rvalid === 1'b1) ? rsp.rdata : 8'hXX;
    req <= '0;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the reset source and remap block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] a_st = rsrm_pkg::ADDR_STATUS;
  localparam logic [31:0] a_cl = rsrm_pkg::ADDR_CLEAR;
  localparam logic [31:0] a_rm = rsrm_pkg::ADDR_REMAP;
  logic        clk = 1'b0, rst_n = 1'b0, ext = 1'b0, wdt = 1'b0, dl, rm;
  logic        sel_s, sel_f, sys_n, remap, sval;
  logic [31:0] caddr = 32'h00000000, seed = 32'h00008E09;
  logic [7:0]  got, st = 8'h01;
  logic [7:0]  hv_cfg = 8'h04, hv_sta = 8'h40;
  int          fails = 0, checks_done = 0;
  rsrm_pkg::rsrm_req_type req;
  rsrm_pkg::rsrm_rsp_type rsp;
  always #2.5 clk = ~clk;
  rsrm_top rsrm_top_i (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp),
    .ext_pin_reset(ext), .watchdog_timeout(wdt), .download_done(dl),
    .high_voltage_config(hv_cfg), .high_voltage_status(hv_sta),
    .core_addr(caddr), .sel_low_sram(sel_s), .sel_low_flash(sel_f),
    .system_reset_n(sys_n), .remap_sram(remap), .sram_valid(sval));
  rsrm_core_model rsrm_core_model_i (.clk(clk), .req(req), .rsp(rsp));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("checks=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic up();
    for (int i = 0; i < 40 && sys_n !== 1'b1; i++) @(negedge clk);
    chk(sys_n, 1'b1);
  endtask
  task automatic rd_st();
    rsrm_core_model_i.rd(a_st, got);
    chk(got, st);
  endtask
  task automatic dec();
    logic lo;
    repeat (8) begin
      @(negedge clk);
      caddr = rnd() & 32'h0000FFFF;
      lo = caddr < rsrm_pkg::LOW_REGION_BYTES;
      #1 chk({6'h00, sel_s, sel_f}, {6'h00, lo && rm, lo && !rm});
    end
  endtask
  task automatic event_case(input logic w);
    @(negedge clk);
    {wdt, ext} = {w, !w};
    @(negedge clk);
    {wdt, ext} = 2'b00;
    chk(sys_n, 1'b0);
    chk(remap, 1'b0);
    chk(sval, !dl);
    up();
    st = st | (w ? 8'h02 : 8'h08);
    rm = 1'b0;
    rd_st();
  endtask
  initial begin
    dl = 1'(rnd());
    rm = 1'b0;
    #50 rst_n = 1'b1;
    up();
    rd_st();
    chk(sval, 1'b1);
    rsrm_core_model_i.wr(a_rm, 8'h01);
    rm = 1'b1;
    rsrm_core_model_i.rd(a_rm, got);
    chk(got, 8'h01);
    dec();
    event_case(1'b1);
    event_case(1'b0);
    rsrm_core_model_i.wr(a_st, 8'h04);
    chk(sys_n, 1'b0);
    up();
    st = st | 8'h04;
    rd_st();
    rsrm_core_model_i.wr(a_cl, 8'h01);
    chk(sys_n, 1'b0);
    up();
    st = 8'h0E;
    rd_st();
    rsrm_core_model_i.wr(a_cl, 8'h0E);
    chk(sys_n, 1'b1);
    st = 8'h00;
    rd_st();
    rsrm_core_model_i.rd(a_cl, got);
    chk(got, 8'h00);
    rsrm_core_model_i.rd(32'hFFFF0224, got);
    chk(got, 8'h00);
    rsrm_core_model_i.wr(a_rm, 8'h01);
    hv_sta = 8'h00;
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    up();
    rsrm_core_model_i.rd(a_rm, got);
    chk(got, 8'h00);
    st = 8'h01;
    rd_st();
    chk(sval, 1'b0);
    dec();
    results();
  end
  initial begin
    #20000;
    fails++;
    results();
  end
endmodule
`default_nettype wire
